//--- cdd_consts.vh
`ifndef CDD_CONSTS_VH
`define CDD_CONSTS_VH
// opcodes
`define CDD_OP_DEC_ACC 8'h14
`define CDD_OP_DEC_DIR 8'h15
`define CDD_OP_DEC_PTR_MASK 8'hfe
`define CDD_OP_DEC_PTR 8'h16
`define CDD_OP_DEC_BANK_MASK 8'hf8
`define CDD_OP_DEC_BANK 8'h18
`define CDD_OP_DIV 8'h84
// timing
`define CDD_STATES_PER_CYCLE 6
`define CDD_DEC_CYCLES 1
`define CDD_DIV_CYCLES 4
`define CDD_DIV_STATES 5'h18
`define CDD_DEC_STATES 5'h06
// psw flag positions
`define CDD_PSW_CARRY 7
`define CDD_PSW_AUX 6
`define CDD_PSW_OVF 2
// reset values
`define CDD_ACC_RST 8'h00
`define CDD_B_RST 8'h00
`define CDD_PSW_RST 8'h00
// operand kinds
`define CDD_KIND_ACC 3'h0
`define CDD_KIND_DIR 3'h1
`define CDD_KIND_PTR 3'h2
`define CDD_KIND_BANK 3'h3
`define CDD_KIND_DIV 3'h4
`endif

//--- cdd_divider.v
`include "cdd_consts.vh"
`default_nettype none
// ****************************************
// restoring divider, one quotient bit per step
// ****************************************
module cdd_divider #(
  parameter WIDTH = 8
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire start_in,
  input wire [WIDTH-1:0] dividend_in,
  input wire [WIDTH-1:0] divisor_in,
  output reg [WIDTH-1:0] quot_out,
  output reg [WIDTH-1:0] rem_out,
  output reg zero_div_out,
  output reg done_out
);
  reg [WIDTH-1:0] q_r;
  reg [WIDTH:0] rem_r;
  reg [WIDTH-1:0] dvs_r;
  reg [4:0] cnt_r;
  reg busy_r;
  wire [WIDTH:0] shifted = {rem_r[WIDTH-1:0], q_r[WIDTH-1]};
  wire [WIDTH:0] trial = shifted - {1'b0, dvs_r};
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      q_r <= {WIDTH{1'b0}};
      rem_r <= {(WIDTH+1){1'b0}};
      dvs_r <= {WIDTH{1'b0}};
      cnt_r <= 5'h0;
      busy_r <= 1'b0;
      quot_out <= {WIDTH{1'b0}};
      rem_out <= {WIDTH{1'b0}};
      zero_div_out <= 1'b0;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_r) begin
        q_r <= dividend_in;
        rem_r <= {(WIDTH+1){1'b0}};
        dvs_r <= divisor_in;
        cnt_r <= WIDTH[4:0];
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r == 5'h0) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
          quot_out <= q_r;
          rem_out <= rem_r[WIDTH-1:0];
          zero_div_out <= (dvs_r == {WIDTH{1'b0}});
        end else begin
          cnt_r <= cnt_r - 5'h1;
          if (!trial[WIDTH]) begin
            rem_r <= trial;
            q_r <= {q_r[WIDTH-2:0], 1'b1};
          end else begin
            rem_r <= shifted;
            q_r <= {q_r[WIDTH-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- cdd_exec.v
`include "cdd_consts.vh"
`default_nettype none
// Notes on behaviour
// - 00010100 decrements accumulator, six states
// - 00010101 plus address decrements direct byte
// - 0001011i decrements byte at pointer register
// - zero wraps to 0FFH silently
// - port operands read from output latch
// - unsigned A by B divide, 24 states
// - quotient goes to accumulator
// - remainder replaces divisor register
// - nonzero divisor clears carry and overflow
// - zero divisor clears carry, sets overflow
module cdd_exec #(
  parameter STATES_PER_CYCLE = `CDD_STATES_PER_CYCLE
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire issue_in,
  input wire [7:0] opcode_in,
  input wire [7:0] direct_operand_in,
  input wire [7:0] ram_rdata_in,
  input wire [7:0] port_latch_in,
  input wire is_port_in,
  input wire [7:0] pointer_register_in,
  input wire [7:0] banked_register_in,
  input wire [7:0] acc_load_in,
  input wire acc_load_en_in,
  input wire [7:0] b_load_in,
  input wire b_load_en_in,
  input wire [7:0] psw_load_in,
  input wire psw_load_en_in,
  output reg [7:0] acc_out,
  output reg [7:0] b_out,
  output reg [7:0] psw_out,
  output reg busy_out,
  output reg done_out,
  output reg illegal_out,
  output reg [2:0] kind_out,
  output reg mem_we_out,
  output reg [7:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  output reg [2:0] bank_sel_out
);
  // ****************************************
  // states and decode
  // ****************************************
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_DEC = 4'b0010;
  localparam [3:0] ST_DIV = 4'b0100;
  localparam [3:0] ST_WAIT = 4'b1000;
  localparam [4:0] DIV_STATES = `CDD_DIV_STATES;
  localparam [4:0] DEC_STATES = `CDD_DEC_STATES;

  function [2:0] decode_kind;
    input [7:0] op;
    begin
      if (op == `CDD_OP_DEC_ACC)
        decode_kind = `CDD_KIND_ACC;
      else if (op == `CDD_OP_DEC_DIR)
        decode_kind = `CDD_KIND_DIR;
      else if ((op & `CDD_OP_DEC_PTR_MASK) == `CDD_OP_DEC_PTR)
        decode_kind = `CDD_KIND_PTR;
      else if ((op & `CDD_OP_DEC_BANK_MASK) == `CDD_OP_DEC_BANK)
        decode_kind = `CDD_KIND_BANK;
      else if (op == `CDD_OP_DIV)
        decode_kind = `CDD_KIND_DIV;
      else
        decode_kind = 3'h7;
    end
  endfunction

  function [7:0] dec8;
    input [7:0] v;
    begin
      dec8 = v - 8'h01;
    end
  endfunction

  reg [3:0] state_r;
  reg [4:0] st_cnt_r;
  reg [7:0] operand_r;
  reg [2:0] kind_r;
  reg div_start_r;
  wire [7:0] quot;
  wire [7:0] rem;
  wire zero_div;
  wire div_done;
  wire [2:0] kind_w = decode_kind(opcode_in);

  // ****************************************
  // divider
  // ****************************************
  // eight step divide
  cdd_divider #(.WIDTH(8)) u_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .start_in(div_start_r),
    .dividend_in(acc_out),
    .divisor_in(b_out),
    .quot_out(quot),
    .rem_out(rem),
    .zero_div_out(zero_div),
    .done_out(div_done)
  );

  // ****************************************
  // sequencer
  // ****************************************
  // one state per clock; the divider finishes well inside 24
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= ST_IDLE;
      st_cnt_r <= 5'h0;
      operand_r <= 8'h00;
      kind_r <= 3'h0;
      div_start_r <= 1'b0;
      acc_out <= `CDD_ACC_RST;
      b_out <= `CDD_B_RST;
      psw_out <= `CDD_PSW_RST;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      illegal_out <= 1'b0;
      kind_out <= 3'h0;
      mem_we_out <= 1'b0;
      mem_addr_out <= 8'h00;
      mem_wdata_out <= 8'h00;
      bank_sel_out <= 3'h0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      mem_we_out <= 1'b0;
      illegal_out <= 1'b0;
      div_start_r <= 1'b0;
      if (acc_load_en_in && state_r == ST_IDLE)
        acc_out <= acc_load_in;
      if (b_load_en_in && state_r == ST_IDLE)
        b_out <= b_load_in;
      if (psw_load_en_in && state_r == ST_IDLE)
        psw_out <= psw_load_in;
      case (state_r)
        ST_IDLE: begin
          if (issue_in) begin
            kind_r <= kind_w;
            kind_out <= kind_w;
            st_cnt_r <= 5'h1;
            case (kind_w)
              `CDD_KIND_ACC: begin
                operand_r <= acc_out;
                state_r <= ST_DEC;
                busy_out <= 1'b1;
              end
              `CDD_KIND_DIR: begin
                operand_r <= is_port_in ? port_latch_in : ram_rdata_in;
                mem_addr_out <= direct_operand_in;
                state_r <= ST_DEC;
                busy_out <= 1'b1;
              end
              `CDD_KIND_PTR: begin
                operand_r <= ram_rdata_in;
                mem_addr_out <= pointer_register_in;
                state_r <= ST_DEC;
                busy_out <= 1'b1;
              end
              `CDD_KIND_BANK: begin
                operand_r <= banked_register_in;
                bank_sel_out <= opcode_in[2:0];
                state_r <= ST_DEC;
                busy_out <= 1'b1;
              end
              `CDD_KIND_DIV: begin
                div_start_r <= 1'b1;
                state_r <= ST_DIV;
                busy_out <= 1'b1;
              end
              default: begin
                illegal_out <= 1'b1;
              end
            endcase
          end
        end
        ST_DEC: begin
          st_cnt_r <= st_cnt_r + 5'h1;
          if (st_cnt_r == DEC_STATES) begin
            // wrap 00 to FF; psw untouched
            if (kind_r == `CDD_KIND_ACC)
              acc_out <= dec8(operand_r);
            else begin
              mem_we_out <= 1'b1;
              mem_wdata_out <= dec8(operand_r);
            end
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        ST_DIV: begin
          st_cnt_r <= st_cnt_r + 5'h1;
          if (div_done) begin
            if (!zero_div) begin
              acc_out <= quot;
              b_out <= rem;
            end
            // clear carry, overflow; overflow on zero
            psw_out[`CDD_PSW_CARRY] <= 1'b0;
            psw_out[`CDD_PSW_OVF] <= zero_div;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          st_cnt_r <= st_cnt_r + 5'h1;
          if (st_cnt_r == DIV_STATES) begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- cdd_exec_props.sv
`default_nettype none
module cdd_exec_props (
  input wire logic clk_in, nrst_in, ce_in, issue_in, is_port_in, busy_out, done_out, mem_we_out,
  input wire logic [7:0] opcode_in, direct_operand_in, ram_rdata_in, port_latch_in, pointer_register_in,
  input wire logic [7:0] banked_register_in, acc_out, b_out, psw_out, mem_addr_out, mem_wdata_out,
  input wire logic [2:0] bank_sel_out
);
  // ****************************************
  // issue qualifiers
  // ****************************************
  wire go = ce_in && issue_in && !busy_out;
  wire dec_go = go && (opcode_in[7:2] == 6'h05 || opcode_in[7:3] == 5'h03);
  wire div_go = go && opcode_in == 8'h84;
  wire [2:0] rsel = opcode_in[2:0];
  wire aux = psw_out[6];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  property p_dec_time;
    dec_go |-> ##1 (busy_out && !done_out) [*6] ##1 (done_out && !busy_out);
  endproperty
  a_dec_time: assert property (p_dec_time) else $error("decrement timing wrong");
  property p_dec_flags;
    dec_go |-> ##7 psw_out == $past(psw_out, 7);
  endproperty
  a_dec_flags: assert property (p_dec_flags) else $error("decrement touched flags");
  property p_dec_acc;
    go && opcode_in == 8'h14 |-> ##7 acc_out == $past(acc_out, 7) - 8'h01;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("accumulator decrement wrong");
  property p_dec_dir;
    go && opcode_in == 8'h15 |-> ##7 mem_we_out && mem_addr_out == $past(direct_operand_in, 7) &&
      mem_wdata_out == ($past(is_port_in, 7) ? $past(port_latch_in, 7) : $past(ram_rdata_in, 7)) - 8'h01;
  endproperty
  a_dec_dir: assert property (p_dec_dir) else $error("direct decrement wrong");
  property p_dec_ptr;
    go && opcode_in[7:1] == 7'h0b |-> ##7 mem_we_out && mem_addr_out == $past(pointer_register_in, 7) &&
      mem_wdata_out == $past(ram_rdata_in, 7) - 8'h01;
  endproperty
  a_dec_ptr: assert property (p_dec_ptr) else $error("indirect decrement wrong");
  property p_dec_bank;
    go && opcode_in[7:3] == 5'h03 |-> ##7 mem_we_out && bank_sel_out == $past(rsel, 7) &&
      mem_wdata_out == $past(banked_register_in, 7) - 8'h01;
  endproperty
  a_dec_bank: assert property (p_dec_bank) else $error("register decrement wrong");
  property p_div_time;
    div_go |-> ##25 done_out && !busy_out;
  endproperty
  a_div_time: assert property (p_div_time) else $error("divide timing wrong");
  property p_div_res;
    div_go && b_out != 8'h00 |-> ##25 acc_out == $past(acc_out, 25) / $past(b_out, 25) &&
      b_out == $past(acc_out, 25) % $past(b_out, 25);
  endproperty
  a_div_res: assert property (p_div_res) else $error("divide result wrong");
  property p_div_flags;
    div_go && b_out != 8'h00 |-> ##25 !psw_out[7] && !psw_out[2] && aux == $past(aux, 25);
  endproperty
  a_div_flags: assert property (p_div_flags) else $error("divide flags wrong");
  property p_div_zero;
    div_go && b_out == 8'h00 |-> ##25 !psw_out[7] && psw_out[2] && aux == $past(aux, 25);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("zero divide flags wrong");
endmodule
`default_nettype wire

//--- cpu_decrement_divide_exec_test.sv
`default_nettype none
module cpu_decrement_divide_exec_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 1'h0, nrst_in = 1'h0, ce_in = 1'h1, issue_in = 1'h0, is_port_in = 1'h0;
  logic acc_load_en_in = 1'h0, b_load_en_in = 1'h0, psw_load_en_in = 1'h0;
  logic [7:0] opcode_in = 8'h00, direct_operand_in = 8'h00, ram_rdata_in = 8'h00, port_latch_in = 8'h00;
  logic [7:0] pointer_register_in = 8'h00, banked_register_in = 8'h00, acc_load_in = 8'h00;
  logic [7:0] b_load_in = 8'h00, psw_load_in = 8'h00, acc_out, b_out, psw_out, mem_addr_out, mem_wdata_out;
  logic busy_out, done_out, illegal_out, mem_we_out;
  logic [2:0] kind_out, bank_sel_out;
  int miscompares = 0;
  int checked = 0;
  cdd_exec i_cdd_exec (.*);
  always #2.5 clk_in = ~clk_in;
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (checked > 0 && miscompares == 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // core loads only while idle
  task automatic preset(input logic [7:0] a, input logic [7:0] b, input logic [7:0] p);
    @(negedge clk_in);
    {acc_load_in, b_load_in, psw_load_in} = {a, b, p};
    {acc_load_en_in, b_load_en_in, psw_load_en_in} = 3'h7;
    @(negedge clk_in);
    {acc_load_en_in, b_load_en_in, psw_load_en_in} = 3'h0;
  endtask
  // returns at the cycle done is seen, while write pulse still stands
  task automatic run(input logic [7:0] op, input int cyc);
    int n;
    @(negedge clk_in);
    opcode_in = op;
    issue_in = 1'h1;
    @(negedge clk_in);
    issue_in = 1'h0;
    n = 0;
    while (done_out !== 1'h1 && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    chk(8'(n), 8'(cyc));
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_dec_acc;
    preset(8'h00, 8'h00, 8'hc4);
    run(8'h14, 6);
    chk(acc_out, 8'hff);
    chk({5'h00, kind_out}, 8'h00);
    chk({7'h00, mem_we_out}, 8'h00);
    chk(psw_out, 8'hc4);
    run(8'h14, 6);
    chk(acc_out, 8'hfe);
  endtask
  task automatic t_dec_dir;
    {direct_operand_in, ram_rdata_in, port_latch_in} = {8'h30, 8'h00, 8'h5a};
    run(8'h15, 6);
    chk({7'h00, mem_we_out}, 8'h01);
    chk(mem_addr_out, 8'h30);
    chk(mem_wdata_out, 8'hff);
    is_port_in = 1'h1;
    run(8'h15, 6);
    chk(mem_wdata_out, 8'h59);
    is_port_in = 1'h0;
  endtask
  task automatic t_dec_ptr;
    for (int i = 0; i < 2; i++) begin
      {pointer_register_in, ram_rdata_in} = {8'h7f - 8'(i), 8'h40};
      run(8'h16 + 8'(i), 6);
      chk(mem_addr_out, 8'h7f - 8'(i));
      chk(mem_wdata_out, 8'h3f);
    end
  endtask
  task automatic t_dec_bank;
    for (int r = 0; r < 8; r++) begin
      banked_register_in = 8'(r * 17);
      run(8'h18 + 8'(r), 6);
      chk({5'h00, bank_sel_out}, 8'(r));
      chk(mem_wdata_out, 8'(r * 17 - 1));
    end
  endtask
  task automatic t_div;
    preset(8'hfb, 8'h12, 8'hc4);
    run(8'h84, 24);
    chk({5'h00, kind_out}, 8'h04);
    chk(acc_out, 8'h0d);
    chk(b_out, 8'h11);
    chk(psw_out, 8'h40);
    preset(8'h55, 8'h00, 8'h80);
    run(8'h84, 24);
    chk(psw_out, 8'h04);
  endtask
  // unknown opcode: one-cycle flag and kind 7, no busy
  task automatic t_illegal;
    @(negedge clk_in);
    {opcode_in, issue_in} = {8'ha5, 1'h1};
    @(negedge clk_in);
    issue_in = 1'h0;
    chk({7'h00, illegal_out}, 8'h01);
    chk({5'h00, kind_out}, 8'h07);
    @(negedge clk_in);
    chk({7'h00, illegal_out}, 8'h00);
    chk({7'h00, busy_out}, 8'h00);
  endtask
  initial begin
    repeat (5) @(negedge clk_in);
    nrst_in = 1'h1;
    t_dec_acc;
    t_dec_dir;
    t_dec_ptr;
    t_dec_bank;
    t_div;
    t_illegal;
    give_verdict;
  end
  // whole run is under two hundred cycles
  initial begin
    #20us;
    miscompares++;
    give_verdict;
  end
endmodule
bind cdd_exec cdd_exec_props i_props (.*);
`default_nettype wire
